// >>> design/owm_master.sv
`timescale 1ns/1ps
`include "owm_consts.svh"

// Function
// - the reset pulse holds the line low for at least 480 us, here 511 us.
// - after the reset pulse the line stays released at least 480 us, here 512 us, before any slot.
// - a zero bit drives the line low 60 to 120 us, here 100 us, then releases it.
// - a write-zero slot lasts at most 120 us, here 117 us in total.
// - a one bit or read slot drives low only 1 to 15 us, here 5 us.
// - a write-one or read slot lasts 60 to 120 us, here 117 us.
module owm_master
	import owm_pkg::*;
(
	// clock and reset
	input  wire logic I_MCLK,
	input  wire logic I_RST,
	// command stream
	input  wire logic       I_CMD_VALID,
	output logic            O_CMD_READY,
	input  wire logic [1:0] I_CMD,
	// result stream
	output logic O_RES_VALID,
	output logic O_RES_BIT,
	output logic O_RES_PRESENCE,
	// line
	input  wire logic I_LINE,
	output logic      O_LINE,
	output logic      O_LINE_OE,
	// status
	output logic O_BUSY
);
	localparam int CW = `OWM_CNT_W;

	state_t          state;
	logic [CW-1:0]   cnt;
	logic            line_meta;
	logic            line_sync;
	logic            found;
	logic            bit_in;
	cmd_t            cur;
	logic            buf_valid;
	logic            take;
	cmd_t            buf_cmd;
	logic            cmd_ready;
	// handshake and result helpers
	logic            cmd_push;
	logic            next_cmd_ready;
	logic            res_done;
	logic            in_window;
	logic            sample_now;

	// a stall downstream of the buffer keeps words safe upstream
	owm_skid u_buf (
		.i_clk   (I_MCLK),
		.i_rst   (I_RST),
		.i_valid (cmd_push),
		.o_ready (cmd_ready),
		.i_data  (I_CMD),
		.o_valid (buf_valid),
		.i_ready (take),
		.o_data  (buf_cmd)
	);

	assign take = (state == ST_IDLE) && buf_valid && !O_RES_VALID;

	function automatic logic [CW-1:0] low_len(input cmd_t c);
		unique case (c)
			`OWM_CMD_RESET:  low_len = CW'(`OWM_RESET_LOW_CYC);
			`OWM_CMD_WRITE0: low_len = CW'(`OWM_ZERO_LOW_CYC);
			`OWM_CMD_WRITE1: low_len = CW'(`OWM_SHORT_LOW_CYC);
			`OWM_CMD_READ:   low_len = CW'(`OWM_SHORT_LOW_CYC);
		endcase
	endfunction : low_len

	// low phase of either kind of sequence
	function automatic logic in_low(input state_t s);
		in_low = (s == ST_RESET_LOW) || (s == ST_SLOT_LOW);
	endfunction : in_low

	// released tail of either kind of sequence
	function automatic logic in_tail(input state_t s);
		in_tail = (s == ST_RESET_HIGH) || (s == ST_SLOT_HIGH);
	endfunction : in_tail

	// the outside judges the handshake on the registered ready, so the buffer pushes on that same ready
	assign cmd_push       = I_CMD_VALID && O_CMD_READY;
	assign next_cmd_ready = take || (cmd_ready && !(buf_valid && cmd_push));
	assign res_done       = in_tail(state) && cnt == '0;
	assign in_window      = (cnt <= CW'(`OWM_RESET_HIGH_CYC - `OWM_PRESENCE_WAIT_CYC)) &&
	                        (cnt >= CW'(`OWM_RESET_HIGH_CYC - `OWM_PRESENCE_END_CYC));
	assign sample_now     = (cur == `OWM_CMD_READ) && (cnt == CW'(`OWM_SLOT_CYC - `OWM_SAMPLE_CYC - 1));

	// pin crosses into the clock domain through two flops
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			line_meta <= 1'b1;
			line_sync <= 1'b1;
		end else begin
			line_meta <= I_LINE;
			line_sync <= line_meta;
		end
	end

	// sequencer; every sequence ends in its released tail, and the result pulse
	// blocks the next take, so two idle cycles always separate two sequences
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			state <= ST_IDLE;
			cnt   <= '0;
			cur   <= `OWM_CMD_RESET;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (take) begin
						cur   <= buf_cmd;
						cnt   <= low_len(buf_cmd) - CW'(1);
						state <= (buf_cmd == `OWM_CMD_RESET) ? ST_RESET_LOW : ST_SLOT_LOW;
					end
				end
				ST_RESET_LOW: begin
					if (cnt == '0) begin
						cnt   <= CW'(`OWM_RESET_HIGH_CYC - 1);
						state <= ST_RESET_HIGH;
					end else
						cnt <= cnt - CW'(1);
				end
				ST_RESET_HIGH: begin
					if (cnt == '0)
						state <= ST_IDLE;
					else
						cnt <= cnt - CW'(1);
				end
				ST_SLOT_LOW: begin
					if (cnt == '0) begin
						// rest of slot, so the whole slot is 117 us
						cnt   <= CW'(`OWM_SLOT_CYC) - low_len(cur) - CW'(1);
						state <= ST_SLOT_HIGH;
					end else
						cnt <= cnt - CW'(1);
				end
				ST_SLOT_HIGH: begin
					if (cnt == '0)
						state <= ST_IDLE;
					else
						cnt <= cnt - CW'(1);
				end
			endcase
		end
	end

	// open-drain: the data level is tied low, only the enable moves
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			O_LINE <= 1'b0;
		else
			O_LINE <= 1'b0;
	end

	// enable rises on the take edge and falls on the last count of the low phase
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			O_LINE_OE <= 1'b0;
		else
			O_LINE_OE <= take || (in_low(state) && cnt != '0);
	end

	// presence window covers the latest start plus the longest pulse;
	// the two-cycle sync delay is small against it
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			found <= 1'b0;
		else if (state == ST_RESET_LOW)
			found <= 1'b0;
		else if (state == ST_RESET_HIGH && in_window && !line_sync)
			found <= 1'b1;
	end

	// read sample taken while a slave answering zero still holds the line
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			bit_in <= 1'b1;
		else if (state == ST_SLOT_LOW && cur == `OWM_CMD_READ)
			bit_in <= 1'b1;
		else if (state == ST_SLOT_HIGH && sample_now)
			bit_in <= line_sync;
	end

	// result word, one per command; the bit holds until the next result, presence until the next reset result
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			O_RES_VALID    <= 1'b0;
			O_RES_BIT      <= 1'b0;
			O_RES_PRESENCE <= 1'b0;
		end else begin
			O_RES_VALID <= res_done;
			if (res_done)
				O_RES_BIT <= (cur == `OWM_CMD_READ) ? bit_in : (cur == `OWM_CMD_WRITE1);
			if (res_done && state == ST_RESET_HIGH)
				O_RES_PRESENCE <= found;
		end
	end

	// status
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			O_BUSY <= 1'b0;
		else
			O_BUSY <= (state != ST_IDLE) || buf_valid;
	end

	// ready is a flop of its own, so it looks one push ahead and never promises a full buffer
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			O_CMD_READY <= 1'b0;
		else
			O_CMD_READY <= next_cmd_ready;
	end
endmodule : owm_master

// >>> design/owm_consts.svh
`ifndef OWM_CONSTS_SVH
`define OWM_CONSTS_SVH

// clock rate in kHz, period 100 ns
`define OWM_CLK_KHZ             10000
// times in microseconds
`define OWM_RESET_LOW_US        511
`define OWM_RESET_HIGH_US       512
`define OWM_PRESENCE_WAIT_US    15
`define OWM_PRESENCE_END_US     300
`define OWM_ZERO_LOW_US         100
`define OWM_SHORT_LOW_US        5
`define OWM_SAMPLE_US           13
`define OWM_SLOT_US             117
// cycle counts derived from the times
`define OWM_RESET_LOW_CYC       ((`OWM_RESET_LOW_US * `OWM_CLK_KHZ + 999) / 1000)
`define OWM_RESET_HIGH_CYC      ((`OWM_RESET_HIGH_US * `OWM_CLK_KHZ + 999) / 1000)
`define OWM_PRESENCE_WAIT_CYC   ((`OWM_PRESENCE_WAIT_US * `OWM_CLK_KHZ + 999) / 1000)
`define OWM_PRESENCE_END_CYC    ((`OWM_PRESENCE_END_US * `OWM_CLK_KHZ) / 1000)
`define OWM_ZERO_LOW_CYC        ((`OWM_ZERO_LOW_US * `OWM_CLK_KHZ) / 1000)
`define OWM_SHORT_LOW_CYC       ((`OWM_SHORT_LOW_US * `OWM_CLK_KHZ) / 1000)
`define OWM_SAMPLE_CYC          ((`OWM_SAMPLE_US * `OWM_CLK_KHZ) / 1000)
`define OWM_SLOT_CYC            ((`OWM_SLOT_US * `OWM_CLK_KHZ) / 1000)
`define OWM_CNT_W               13
`define OWM_CMD_RESET           2'h0
`define OWM_CMD_WRITE0          2'h1
`define OWM_CMD_WRITE1          2'h2
`define OWM_CMD_READ            2'h3

`endif

// >>> design/owm_pkg.sv
package owm_pkg;
	typedef logic [1:0] cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RESET_LOW,
		ST_RESET_HIGH,
		ST_SLOT_LOW,
		ST_SLOT_HIGH
	} state_t;
endpackage : owm_pkg

// >>> design/owm_skid.sv
`timescale 1ns/1ps
// two-entry buffer; ready depends only on fill level, so no combinational path crosses it
module owm_skid (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_valid,
	output logic            o_ready,
	input  wire logic [1:0] i_data,
	output logic            o_valid,
	input  wire logic       i_ready,
	output logic [1:0]      o_data
);
	logic [1:0] mem [2];
	logic       wr_ptr;
	logic       rd_ptr;
	logic [1:0] fill;
	logic       push;
	logic       pop;

	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;
	assign o_ready = fill != 2'h2;
	assign o_valid = fill != 2'h0;
	assign o_data  = mem[rd_ptr];

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fill   <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			fill <= fill + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge i_clk) begin
		if (push)
			mem[wr_ptr] <= i_data;
	end
endmodule : owm_skid

// >>> test/owm_master_monitor.sv
`timescale 1ns/1ps
module owm_master_monitor (
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic O_LINE,
	input wire logic O_LINE_OE,
	input wire logic O_RES_VALID,
	input wire logic O_RES_BIT,
	input wire logic O_BUSY
);
	int lo;
	int lastlo;
	int hi;
	// hi starts large so the first slot after reset is not judged on a gap it never had
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			lo <= 0;
			lastlo <= 0;
			hi <= 100000;
		end else begin
			lo <= O_LINE_OE ? lo + 1 : 0;
			lastlo <= O_LINE_OE ? lo + 1 : lastlo;
			hi <= O_LINE_OE ? 0 : (hi < 100000 ? hi + 1 : hi);
		end
	end
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	property p_line_low; !O_LINE; endproperty
	a_line_low: assert property (p_line_low) else $error("line driven high");
	property p_low_time; $fell(O_LINE_OE) |-> lo inside {[10:150], [600:1200], [4800:6000]}; endproperty
	a_low_time: assert property (p_low_time) else $error("low phase length wrong");
	property p_reset_gap; $rose(O_LINE_OE) && lastlo >= 4800 |-> hi >= 4800; endproperty
	a_reset_gap: assert property (p_reset_gap) else $error("slot too soon after reset");
	property p_slot_max; $rose(O_RES_VALID) && lastlo < 4800 |-> lastlo + hi <= 1200; endproperty
	a_slot_max: assert property (p_slot_max) else $error("slot too long");
	property p_slot_min; $rose(O_LINE_OE) && lastlo < 4800 |-> lastlo + hi >= 600; endproperty
	a_slot_min: assert property (p_slot_min) else $error("slot too short");
	property p_pulse; O_RES_VALID |=> !O_RES_VALID; endproperty
	a_pulse: assert property (p_pulse) else $error("result pulse too long");
	property p_busy; O_LINE_OE |-> O_BUSY; endproperty
	a_busy: assert property (p_busy) else $error("line pulled while idle");
	property p_bit_hold; !O_RES_VALID |-> $stable(O_RES_BIT); endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("result bit moved");
endmodule : owm_master_monitor

// >>> test/owm_slave.sv
`timescale 1ns/1ps
// behavioural slave; it only ever pulls, the pull-up lives in the bench
module owm_slave (
	input  wire logic i_line,
	input  wire logic i_present,
	input  wire logic i_zero,
	output logic      o_pull
);
	realtime t0;
	initial o_pull = 1'b0;
	always @(negedge i_line) begin
		t0 = $realtime;
		@(posedge i_line);
		if ($realtime - t0 > 480_000 && i_present) begin
			#30_000 o_pull = 1'b1;
			#100_000 o_pull = 1'b0;
		end else if ($realtime - t0 < 15_000 && i_zero) begin
			o_pull = 1'b1;
			#(t0 + 25_000 - $realtime) o_pull = 1'b0;
		end
	end
endmodule : owm_slave

// >>> test/testbench.sv
`timescale 1ns/1ps
`include "owm_consts.svh"
module testbench;
	import owm_pkg::*;
	logic clk = 1'b0, rst = 1'b1, vld = 1'b0, present = 1'b0, zero = 1'b0;
	cmd_t cmd = 2'h0;
	logic rdy, rv, rb, rp, o_line, oe, busy, pull;
	wire  line = (oe ? o_line : 1'b1) && !pull;
	int   miscompares = 0, checked = 0;
	always #50 clk = !clk;
	owm_master dut (.I_MCLK(clk), .I_RST(rst), .I_CMD_VALID(vld), .O_CMD_READY(rdy), .I_CMD(cmd), .O_RES_VALID(rv),
		.O_RES_BIT(rb), .O_RES_PRESENCE(rp), .I_LINE(line), .O_LINE(o_line), .O_LINE_OE(oe), .O_BUSY(busy));
	owm_slave slave (.i_line(line), .i_present(present), .i_zero(zero), .o_pull(pull));
	task check(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// ready is read just after an edge, which is the value the next edge will act on
	task send(input cmd_t c);
		logic ok;
		@(posedge clk);
		#1 vld = 1'b1;
		cmd = c;
		ok = rdy;
		@(posedge clk);
		while (ok !== 1'b1) begin
			#1 ok = rdy;
			@(posedge clk);
		end
		#1 vld = 1'b0;
	endtask : send
	// bounded so a lost result cannot hang the run; outputs are read once settled
	task wait_res;
		int n;
		n = 0;
		@(posedge clk);
		#1;
		while (rv !== 1'b1 && n < 20000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 20000) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, rv, 1'b1);
		end
	endtask : wait_res
	task s_reset(input logic p);
		present = p;
		send(`OWM_CMD_RESET);
		wait_res;
		check(rp, p);
	endtask : s_reset
	// four commands queued at once, so the buffer fills and holds the last one back
	task s_bits(input logic z);
		zero = z;
		fork
			begin
				send(`OWM_CMD_WRITE0);
				send(`OWM_CMD_WRITE1);
				send(`OWM_CMD_READ);
				send(`OWM_CMD_READ);
			end
			begin
				wait_res;
				check(rb, 1'b0);
				wait_res;
				check(rb, 1'b1);
				wait_res;
				check(rb, !z);
				wait_res;
				check(rb, !z);
			end
		join
	endtask : s_bits
	task report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		s_reset(1'b1);
		s_bits(1'b1);
		s_reset(1'b0);
		s_bits(1'b0);
		@(posedge clk);
		#1 check(busy, 1'b0);
		check(rdy, 1'b1);
		report_and_stop;
	end
	initial begin
		#6_000_000;
		miscompares++;
		report_and_stop;
	end
endmodule : testbench
bind owm_master owm_master_monitor mon (.I_MCLK(I_MCLK), .I_RST(I_RST), .O_LINE(O_LINE), .O_LINE_OE(O_LINE_OE),
	.O_RES_VALID(O_RES_VALID), .O_RES_BIT(O_RES_BIT), .O_BUSY(O_BUSY));
